// >>> frs_top.sv
// Purpose: Overcurrent fault restart sequencer with Wishbone registers.
// Assumes: Pins are asynchronous; bias loss is seen as rst_n.
// Notes:   Output enable is the converter's power stage enable.
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module frs_top
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   // Converter pins
   input  wire logic        oc_fault_pin,
   input  wire logic        low_vout_pin,
   input  wire logic        ctrl_on_pin,
   output var  logic        output_enable,
   output var  logic        current_limit,
   // Interrupt
   output var  logic        irq
);

   // Pin synchronisation
   logic [2:0] pins_s;
   logic       oc_s;
   logic       lv_s;
   logic       ctrl_s;

   frs_sync #(.W(3)) u_sync
   (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({oc_fault_pin, low_vout_pin, ctrl_on_pin}),
      .q     (pins_s)
   );

   assign oc_s   = pins_s[2];
   assign lv_s   = pins_s[1];
   assign ctrl_s = pins_s[0];

   // Register state
   localparam int IRQ_W = frs_pkg::IRQ_W;

   logic [7:0]       resp_q;
   logic [15:0]      unit_q;
   logic             oper_q;
   logic             fault_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_en_q;
   logic             ack_q;
   logic [31:0]      rdat_q;

   // Fields
   logic [1:0] resp_f;
   logic [2:0] retry_f;
   logic [2:0] delay_f;

   assign resp_f  = resp_q[frs_pkg::RESP_HI:frs_pkg::RESP_LO];
   assign retry_f = resp_q[frs_pkg::RETRY_HI:frs_pkg::RETRY_LO];
   assign delay_f = resp_q[frs_pkg::DELAY_HI:frs_pkg::DELAY_LO];

   // Bus decode
   logic bus_req;
   logic wr_stb;
   logic clr_cmd;
   logic clr_stat;

   assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_stb  = bus_req && wb_we_i && wb_sel_i[0];
   assign clr_cmd = wr_stb && (wb_adr_i == frs_pkg::ADR_CLEAR)
                    && wb_dat_i[frs_pkg::CLR_CMD_BIT];
   assign clr_stat = wr_stb && (wb_adr_i == frs_pkg::ADR_CLEAR)
                     && wb_dat_i[frs_pkg::CLR_STAT_BIT];

   // Commanded on: operation command and control pin together
   logic on_cmd;
   logic on_cmd_q;
   logic on_rise;
   logic fault_clear;

   assign on_cmd  = oper_q && ctrl_s;
   assign on_rise = on_cmd && !on_cmd_q;
   // Any clearing event not met by a new fault in the same cycle drops the latched fault
   assign fault_clear = clr_cmd || clr_stat || on_rise;

   // Sequencer
   frs_pkg::frs_state_e state_q;
   frs_pkg::frs_state_e state_d;
   logic [2:0]          att_q;
   logic                tmr_start;
   logic                tmr_busy;
   logic                tmr_done;
   logic                fault_ev;
   logic                retry_ev;
   logic                lock_ev;
   logic                shut_now;
   logic                can_retry;

   frs_timer #(.UW(16), .EW(3)) u_timer
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .start    (tmr_start),
      .abort    (!on_cmd),
      .unit_cyc (unit_q),
      .exp_n    (delay_f),
      .busy     (tmr_busy),
      .done     (tmr_done)
   );

   // Fresh fault seen while the stage runs
   assign fault_ev = (state_q == frs_pkg::ST_RUN) && oc_s && on_cmd;

   // Response decides whether a run-time fault shuts down now
   always_comb
   begin
      shut_now = 1'b0;
      unique case (resp_f)
         frs_pkg::RSP_IGNORE:  shut_now = 1'b0;
         frs_pkg::RSP_COND_CC: shut_now = lv_s;
         frs_pkg::RSP_DLY_CC:  shut_now = 1'b0;
         frs_pkg::RSP_DISABLE: shut_now = 1'b1;
      endcase
   end

   // Retry budget left after a shutdown
   always_comb
   begin
      if (retry_f == frs_pkg::RETRY_NONE)
         can_retry = 1'b0;
      else if (retry_f == frs_pkg::RETRY_CONT)
         can_retry = 1'b1;
      else
         can_retry = (att_q < retry_f);
   end

   always_comb
   begin
      state_d   = state_q;
      tmr_start = 1'b0;
      retry_ev  = 1'b0;
      lock_ev   = 1'b0;
      if (!on_cmd)
      begin
         state_d = frs_pkg::ST_OFF;
      end
      else
      begin
         unique case (state_q)
            frs_pkg::ST_OFF:
            begin
               state_d = frs_pkg::ST_RUN;
            end
            frs_pkg::ST_RUN:
            begin
               if (oc_s && shut_now)
               begin
                  if (can_retry)
                  begin
                     state_d   = frs_pkg::ST_WAIT;
                     tmr_start = 1'b1;
                  end
                  else
                  begin
                     state_d = frs_pkg::ST_LOCKED;
                     lock_ev = 1'b1;
                  end
               end
               else if (oc_s && resp_f == frs_pkg::RSP_DLY_CC)
               begin
                  state_d   = frs_pkg::ST_HOLD;
                  tmr_start = 1'b1;
               end
            end
            frs_pkg::ST_HOLD:
            begin
               if (!oc_s)
               begin
                  state_d = frs_pkg::ST_RUN;
               end
               else if (tmr_done)
               begin
                  if (can_retry)
                  begin
                     state_d   = frs_pkg::ST_WAIT;
                     tmr_start = 1'b1;
                  end
                  else
                  begin
                     state_d = frs_pkg::ST_LOCKED;
                     lock_ev = 1'b1;
                  end
               end
            end
            frs_pkg::ST_WAIT:
            begin
               if (tmr_done)
               begin
                  state_d  = frs_pkg::ST_RUN;
                  retry_ev = 1'b1;
               end
            end
            frs_pkg::ST_LOCKED:
            begin
               if (fault_clear)
                  state_d = frs_pkg::ST_RUN;
            end
            default:
            begin
               state_d = frs_pkg::ST_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= frs_pkg::ST_OFF;
      else
         state_q <= state_d;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         on_cmd_q <= 1'b0;
      else
         on_cmd_q <= on_cmd;
   end

   // Attempt counter
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         att_q <= '0;
      else if (!on_cmd || fault_clear)
         att_q <= '0;
      else if (retry_ev && retry_f != frs_pkg::RETRY_CONT)
         att_q <= att_q + 3'h1;
   end

   // Latched fault status; a new fault beats a clear
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         fault_q <= 1'b0;
      else if (fault_ev)
         fault_q <= 1'b1;
      else if (fault_clear)
         fault_q <= 1'b0;
   end

   // Power stage outputs
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         output_enable <= 1'b0;
         current_limit <= 1'b0;
      end
      else
      begin
         output_enable <= (state_d == frs_pkg::ST_RUN)
                          || (state_d == frs_pkg::ST_HOLD);
         current_limit <= oc_s && ((state_d == frs_pkg::ST_RUN)
                          || (state_d == frs_pkg::ST_HOLD));
      end
   end

   // Writable registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         resp_q   <= frs_pkg::RESP_RST;
         unit_q   <= frs_pkg::UNIT_CYC_RST;
         oper_q   <= frs_pkg::OPER_RST;
         irq_en_q <= '0;
      end
      else if (wr_stb)
      begin
         unique case (wb_adr_i)
            frs_pkg::ADR_RESP:   resp_q <= wb_dat_i[7:0];
            frs_pkg::ADR_UNIT:
            begin
               unit_q[7:0] <= wb_dat_i[7:0];
               if (wb_sel_i[1])
                  unit_q[15:8] <= wb_dat_i[15:8];
            end
            frs_pkg::ADR_OPER:   oper_q <= wb_dat_i[0];
            frs_pkg::ADR_IRQ_EN: irq_en_q <= wb_dat_i[IRQ_W-1:0];
            default:             ;
         endcase
      end
   end

   // Sticky events; a set in the same cycle as its clear wins
   logic [IRQ_W-1:0] ev_set;
   logic [IRQ_W-1:0] ev_clr;

   assign ev_set = {lock_ev, retry_ev, fault_ev};
   assign ev_clr = (wr_stb && wb_adr_i == frs_pkg::ADR_IRQ_CLR)
                   ? wb_dat_i[IRQ_W-1:0] : '0;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_stat_q <= '0;
      else
         irq_stat_q <= (irq_stat_q & ~ev_clr) | ev_set;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= |(irq_stat_q & irq_en_q);
   end

   // Read mux, registered with the acknowledge
   logic [31:0] rdat_d;

   always_comb
   begin
      rdat_d = '0;
      unique case (wb_adr_i)
         frs_pkg::ADR_RESP:     rdat_d[7:0] = resp_q;
         frs_pkg::ADR_UNIT:     rdat_d[15:0] = unit_q;
         frs_pkg::ADR_OPER:     rdat_d[0] = oper_q;
         frs_pkg::ADR_STATUS:
         begin
            rdat_d[frs_pkg::ST_FAULT]  = fault_q;
            rdat_d[frs_pkg::ST_OUT_EN] = output_enable;
            rdat_d[frs_pkg::ST_LIMIT]  = current_limit;
            rdat_d[6:4]                = state_q;
            rdat_d[frs_pkg::ST_ATT_LO +: 3] = att_q;
         end
         frs_pkg::ADR_IRQ_STAT: rdat_d[IRQ_W-1:0] = irq_stat_q;
         frs_pkg::ADR_IRQ_EN:   rdat_d[IRQ_W-1:0] = irq_en_q;
         default:               rdat_d = '0;
      endcase
   end

   // One wait state: ack rises the cycle after the request, then drops
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_q  <= 1'b0;
         rdat_q <= '0;
      end
      else
      begin
         ack_q <= bus_req;
         if (bus_req && !wb_we_i)
            rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

endmodule
`default_nettype wire

// >>> frs_pkg.sv
// Purpose: Shared constants for the fault restart sequencer.
// Assumes: 50 MHz clk, classic Wishbone register access.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package frs_pkg;

   // Register byte offsets
   localparam logic [7:0] ADR_RESP     = 8'h00;
   localparam logic [7:0] ADR_UNIT     = 8'h04;
   localparam logic [7:0] ADR_OPER     = 8'h08;
   localparam logic [7:0] ADR_CLEAR    = 8'h0c;
   localparam logic [7:0] ADR_STATUS   = 8'h10;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h14;
   localparam logic [7:0] ADR_IRQ_CLR  = 8'h18;
   localparam logic [7:0] ADR_IRQ_EN   = 8'h1c;

   // Fields of the overcurrent response setting
   localparam int RESP_HI  = 7;
   localparam int RESP_LO  = 6;
   localparam int RETRY_HI = 5;
   localparam int RETRY_LO = 3;
   localparam int DELAY_HI = 2;
   localparam int DELAY_LO = 0;

   // Response codes
   localparam logic [1:0] RSP_IGNORE  = 2'h0;
   localparam logic [1:0] RSP_COND_CC = 2'h1;
   localparam logic [1:0] RSP_DLY_CC  = 2'h2;
   localparam logic [1:0] RSP_DISABLE = 2'h3;

   // Retry codes
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_CONT = 3'h7;

   // Clear register bits
   localparam int CLR_CMD_BIT  = 0;
   localparam int CLR_STAT_BIT = 1;

   // Status register bits
   localparam int ST_FAULT  = 0;
   localparam int ST_OUT_EN = 1;
   localparam int ST_LIMIT  = 2;
   localparam int ST_ATT_LO = 8;

   // Interrupt event bits
   localparam int IRQ_W     = 3;
   localparam int EV_FAULT  = 0;
   localparam int EV_RETRY  = 1;
   localparam int EV_LOCKED = 2;

   // Reset values
   localparam logic [7:0] RESP_RST = 8'hc0;
   localparam logic       OPER_RST = 1'b0;

   // Delay time unit default: 1000 us at the clk rate
   localparam int CLK_MHZ      = 50;
   localparam int UNIT_US_RST  = 1000;
   localparam logic [15:0] UNIT_CYC_RST = 16'(UNIT_US_RST * CLK_MHZ);

   // Sequencer states, Gray along off-run-hold-wait-locked
   typedef enum logic [2:0] {
      ST_OFF    = 3'b000,
      ST_RUN    = 3'b001,
      ST_HOLD   = 3'b011,
      ST_WAIT   = 3'b010,
      ST_LOCKED = 3'b110
   } frs_state_e;

endpackage

// >>> frs_sync.sv
// Purpose: Two flip-flop synchroniser for asynchronous pins.
// Assumes: Each bit is an independent level.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
module frs_sync
#(
   parameter int W = 1
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         q      <= '0;
      end
      else
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule
`default_nettype wire

// >>> frs_timer.sv
// Purpose: Interval timer of two to the power n delay time units.
// Assumes: unit_cyc is clk cycles per unit; zero counts as one.
// Notes:   done is a one-cycle pulse; start restarts a running timer.
`timescale 1ns/10ps
`default_nettype none
module frs_timer
#(
   parameter int UW = 16,
   parameter int EW = 3
)
(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // Control
   input  wire logic          start,
   input  wire logic          abort,
   input  wire logic [UW-1:0] unit_cyc,
   input  wire logic [EW-1:0] exp_n,
   // Result
   output var  logic          busy,
   output var  logic          done
);

   localparam int CW = (1 << EW) + 1;

   if (UW < 1 || EW < 1 || EW > 4)
   begin : g_bad_width
      $error("frs_timer: unsupported widths");
   end

   logic [UW-1:0] pre_q;
   logic [CW-1:0] units_q;
   logic [CW-1:0] target;
   logic          tick;

   assign target = CW'(1) << exp_n;
   assign tick   = busy && (pre_q + UW'(1) >= unit_cyc);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre_q   <= '0;
         units_q <= '0;
         busy    <= 1'b0;
         done    <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (abort)
         begin
            busy <= 1'b0;
         end
         else if (start)
         begin
            pre_q   <= '0;
            units_q <= '0;
            busy    <= 1'b1;
         end
         else if (tick)
         begin
            pre_q   <= '0;
            units_q <= units_q + CW'(1);
            if (units_q + CW'(1) == target)
            begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
         else if (busy)
         begin
            pre_q <= pre_q + UW'(1);
         end
      end
   end

endmodule
`default_nettype wire

// >>> frs_top_properties.sv
// Purpose: Port assertions for the fault restart sequencer.
// Assumes: Shadows follow register writes seen at ack.
// Notes:   Shadows lag the design by one cycle, so checks allow it.
`timescale 1ns/10ps
`default_nettype none
module frs_chk
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Bus
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic        wb_ack_o,
   // Pins
   input  wire logic        oc_fault_pin,
   input  wire logic        ctrl_on_pin,
   input  wire logic        output_enable,
   input  wire logic        irq
);
   logic [7:0]  resp_q;
   logic [15:0] unit_q;
   logic [2:0]  en_q;
   logic        retry_q;
   logic [2:0]  tries_q;
   logic [23:0] low_q;
   logic [23:0] gap;
   logic        wr;
   logic        tk;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
   assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
   assign gap = 24'(unit_q == 16'h0 ? 16'h1 : unit_q) << resp_q[2:0];
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         resp_q <= frs_pkg::RESP_RST;
         unit_q <= frs_pkg::UNIT_CYC_RST;
         en_q <= 3'h0;
      end
      else if (wr)
      begin
         if (wb_adr_i == frs_pkg::ADR_RESP)
            resp_q <= wb_dat_i[7:0];
         if (wb_adr_i == frs_pkg::ADR_UNIT)
            unit_q <= {wb_sel_i[1] ? wb_dat_i[15:8] : unit_q[15:8],
                       wb_dat_i[7:0]};
         if (wb_adr_i == frs_pkg::ADR_IRQ_EN)
            en_q <= wb_dat_i[2:0];
      end
   // A fault shutdown arms the spacing check; an on/off or clear write
   // disarms it at the edge the design takes it, as a clear restarts at once
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         retry_q <= 1'b0;
         tries_q <= 3'h0;
         low_q <= 24'h0;
      end
      else
      begin
         low_q <= output_enable ? 24'h0 : low_q + 24'h1;
         if (tk && (wb_adr_i == frs_pkg::ADR_OPER
                    || wb_adr_i == frs_pkg::ADR_CLEAR))
         begin
            retry_q <= 1'b0;
            tries_q <= 3'h0;
         end
         else if ($fell(output_enable) && oc_fault_pin)
            retry_q <= 1'b1;
         else if ($rose(output_enable) && retry_q)
            tries_q <= tries_q + 3'h1;
      end
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held past one cycle");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("request not acked next cycle");
   reset_quiet_a: assert property ($rose(rst_n)
      |-> !output_enable && !irq && !wb_ack_o)
      else $error("outputs active after reset");
   fault_shut_a: assert property (
      $rose(oc_fault_pin) && resp_q[7:6] == 2'h3 && output_enable
      |-> ##[1:6] !output_enable) else $error("fault did not shut output");
   retry_gap_a: assert property (
      $rose(output_enable) && retry_q |-> low_q >= gap && low_q <= gap + 24'h4)
      else $error("restart spacing wrong");
   retry_limit_a: assert property (
      $rose(output_enable) && retry_q
      |-> resp_q[5:3] == 3'h7 || tries_q < resp_q[5:3])
      else $error("too many restarts");
   off_cmd_a: assert property (!ctrl_on_pin [*6] |-> !output_enable)
      else $error("output on while pin commands off");
   enable_cause_a: assert property ($rose(output_enable)
      |-> $past(ctrl_on_pin, 3)) else $error("output on without pin on");
   irq_mask_a: assert property ((en_q == 3'h0) [*2] |-> !irq)
      else $error("irq while all masked");
endmodule
bind frs_top frs_chk u_chk
(
   .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .oc_fault_pin(oc_fault_pin),
   .ctrl_on_pin(ctrl_on_pin), .output_enable(output_enable), .irq(irq)
);
`default_nettype wire

// >>> frs_stage.sv
// Purpose: Behavioural power stage facing the sequencer.
// Assumes: A short draws excess current only while enabled.
// Notes:   So every restart into a short faults again.
`timescale 1ns/10ps
`default_nettype none
module frs_stage
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Stage
   input  wire logic short_cmd,
   input  wire logic output_enable,
   output var  logic oc_fault_pin,
   output var  logic low_vout_pin
);
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         oc_fault_pin <= 1'b0;
         low_vout_pin <= 1'b0;
      end
      else
      begin
         oc_fault_pin <= short_cmd && output_enable;
         low_vout_pin <= short_cmd && output_enable;
      end
endmodule
`default_nettype wire

// >>> frs_top_bench.sv
// Purpose: Self-checking bench for the fault restart sequencer.
// Assumes: Delay unit shortened to 4 clk cycles.
// Notes:   Restart spacing is judged by the checker.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin \
   n_errors++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module frs_top_bench;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        oc_fault_pin;
   logic        low_vout_pin;
   logic        ctrl_on_pin = 1'b0;
   logic        short_cmd = 1'b0;
   logic        output_enable;
   logic        current_limit;
   logic        irq;
   logic        en_d = 1'b0;
   logic [31:0] rd_q;
   int          n_errors = 0;
   int          n_checks = 0;
   int          cycles = 0;
   int          rises = 0;
   int          gap;
   int          base;
   frs_top DUT
   (
      .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .oc_fault_pin(oc_fault_pin), .low_vout_pin(low_vout_pin),
      .ctrl_on_pin(ctrl_on_pin), .output_enable(output_enable),
      .current_limit(current_limit), .irq(irq)
   );
   frs_stage u_stage
   (
      .clk(clk), .rst_n(rst_n), .short_cmd(short_cmd),
      .output_enable(output_enable), .oc_fault_pin(oc_fault_pin),
      .low_vout_pin(low_vout_pin)
   );
   always #10 clk = ~clk;
   task automatic print_verdict();
      if (n_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Sized well past the longest run of the sequence below
   always @(posedge clk)
   begin
      cycles++;
      if (output_enable && !en_d)
         rises++;
      en_d <= output_enable;
      if (cycles == 20000)
      begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk);
      while (wb_ack_o !== 1'b1)
         @(posedge clk);
      rd_q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      wb(1'b0, frs_pkg::ADR_RESP, 32'h0);
      `CHK("resp", 32'hc0, rd_q)
      wb(1'b0, frs_pkg::ADR_UNIT, 32'h0);
      `CHK("unit", 32'(frs_pkg::UNIT_CYC_RST), rd_q)
      wb(1'b0, frs_pkg::ADR_OPER, 32'h0);
      `CHK("oper", 32'h0, rd_q)
      wb(1'b1, 8'h20, 32'hffffffff);
      wb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped", 32'h0, rd_q)
      wb(1'b1, frs_pkg::ADR_UNIT, 32'h4);
      wb(1'b1, frs_pkg::ADR_IRQ_EN, 32'h4);
      ctrl_on_pin <= 1'b1;
      for (int r = 0; r < 7; r++)
      begin
         gap = 4 << r;
         wb(1'b1, frs_pkg::ADR_RESP, {24'h0, 2'h3, 3'(r), 3'(r)});
         short_cmd <= 1'b1;
         base = rises;
         wb(1'b1, frs_pkg::ADR_OPER, 32'h1);
         repeat ((r + 2) * (gap + 30)) @(posedge clk);
         `CHK("starts", r + 1, rises - base)
         wb(1'b0, frs_pkg::ADR_STATUS, 32'h0);
         `CHK("attempts", 3'(r), rd_q[10:8])
         `CHK("locked", 2'h1, rd_q[1:0])
         if (r == 2)
         begin
            `CHK("irq", 1'b1, irq)
            wb(1'b0, frs_pkg::ADR_IRQ_STAT, 32'h0);
            `CHK("events", 3'h7, rd_q[2:0])
            wb(1'b1, frs_pkg::ADR_IRQ_EN, 32'h0);
            repeat (2) @(posedge clk);
            `CHK("masked", 1'b0, irq)
            wb(1'b1, frs_pkg::ADR_IRQ_CLR, 32'h7);
            wb(1'b0, frs_pkg::ADR_IRQ_STAT, 32'h0);
            `CHK("irq clear", 3'h0, rd_q[2:0])
            wb(1'b1, frs_pkg::ADR_IRQ_EN, 32'h4);
         end
         // Even runs use the clear command, odd runs the status bit
         short_cmd <= 1'b0;
         wb(1'b1, frs_pkg::ADR_CLEAR, 32'(1 << (r % 2)));
         wb(1'b0, frs_pkg::ADR_STATUS, 32'h0);
         `CHK("cleared", 4'h0, {rd_q[10:8], rd_q[0]})
         wb(1'b1, frs_pkg::ADR_OPER, 32'h0);
         wb(1'b1, frs_pkg::ADR_OPER, 32'h1);
         repeat (8) @(posedge clk);
         `CHK("back on", 1'b1, output_enable)
         wb(1'b1, frs_pkg::ADR_OPER, 32'h0);
      end
      wb(1'b1, frs_pkg::ADR_IRQ_CLR, 32'h7);
      wb(1'b1, frs_pkg::ADR_RESP, 32'hf9);
      short_cmd <= 1'b1;
      base = rises;
      wb(1'b1, frs_pkg::ADR_OPER, 32'h1);
      repeat (600) @(posedge clk);
      `CHK("endless", 1'b1, (rises - base) > 9)
      wb(1'b0, frs_pkg::ADR_IRQ_STAT, 32'h0);
      `CHK("no lock", 1'b0, rd_q[2])
      ctrl_on_pin <= 1'b0;
      repeat (10) @(posedge clk);
      `CHK("pin off", 1'b0, output_enable)
      wb(1'b0, frs_pkg::ADR_STATUS, 32'h0);
      `CHK("off zeroed", 3'h0, rd_q[10:8])
      wb(1'b1, frs_pkg::ADR_OPER, 32'h0);
      ctrl_on_pin <= 1'b1;
      // Ignore keeps running in limit; the other two lock after one retry
      for (int m = 0; m < 3; m++)
      begin
         short_cmd <= 1'b0;
         wb(1'b1, frs_pkg::ADR_CLEAR, 32'h1);
         wb(1'b1, frs_pkg::ADR_RESP, 32'h08 + 32'(m) * 32'h40);
         short_cmd <= 1'b1;
         base = rises;
         wb(1'b1, frs_pkg::ADR_OPER, 32'h1);
         repeat (100) @(posedge clk);
         `CHK("mode starts", ((m == 0) ? 1 : 2), rises - base)
         `CHK("mode run", (m == 0), output_enable)
         `CHK("limit", (m == 0), current_limit)
         wb(1'b1, frs_pkg::ADR_OPER, 32'h0);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
